// ---- src/tcr_pkg.sv ----
// Shared constants for the timer capture and compare register block.
package tcr_pkg;
    // I/O addresses of the registers on the core's internal I/O port.
    localparam logic [5:0] TCR_ADDR_CTRL_A = 6'h15;
    localparam logic [5:0] TCR_ADDR_MASK = 6'h39;
    localparam logic [5:0] TCR_ADDR_CNT_LO = 6'h32;
    localparam logic [5:0] TCR_ADDR_CNT_HI = 6'h14;
    localparam logic [5:0] TCR_ADDR_CMP_A = 6'h13;
    localparam logic [5:0] TCR_ADDR_CMP_B = 6'h12;
    // Control register A fields.
    localparam int TCR_BIT_WIDTH = 7;
    localparam int TCR_BIT_CAP_EN = 6;
    localparam int TCR_BIT_FILTER = 5;
    localparam int TCR_BIT_EDGE = 4;
    localparam int TCR_BIT_CMP_SRC = 3;
    localparam int TCR_BIT_SEQ = 0;
    localparam logic [7:0] TCR_CTRL_A_WMASK = 8'hF9;
    // Interrupt mask fields owned by this timer.
    localparam int TCR_BIT_IE_CMP_A = 4;
    localparam int TCR_BIT_IE_CMP_B = 3;
    localparam int TCR_BIT_IE_OVF = 1;
    localparam int TCR_BIT_IE_CAP = 0;
    localparam logic [7:0] TCR_MASK_WMASK = 8'h1B;
    // Flag indices for the flag and flag clear vectors.
    localparam int TCR_FLAG_CAP = 0;
    localparam int TCR_FLAG_OVF = 1;
    localparam int TCR_FLAG_CMP_B = 2;
    localparam int TCR_FLAG_CMP_A = 3;
    localparam int TCR_FLAG_COUNT = 4;
    localparam logic [7:0] TCR_RESET_BYTE = 8'h00;
    localparam logic [15:0] TCR_RESET_WORD = 16'h0000;
    localparam logic [7:0] TCR_BYTE_MAX = 8'hFF;
    localparam logic [15:0] TCR_WORD_MAX = 16'hFFFF;
    // Samples the noise filter must see equal before its output moves.
    localparam int TCR_FILTER_LEN = 4;
    typedef enum logic {TCR_SEQ_NORMAL, TCR_SEQ_CTC} tcr_seq_t;
endpackage

// ---- src/tcr_timer.sv ----
// Timer 0 control, counter, compare, capture and shared high-byte latch logic.
// Overview of operation
// R1: Width bit selects 16-bit counter and compare.
// R2: Capture enable bit selects input capture mode.
// R3: Filter needs four equal samples before changing.
// R4: Edge bit zero falling, one rising trigger.
// R5: Capture copies count and sets capture flag.
// R6: Comparator source bit routes comparator into capture.
// R7: Software enables capture interrupt in mask register.
// R8: Control bits 2 and 1 read zero.
// R9: Bit 0 picks normal or clear-on-match counting.
// R10: Counter low write blocks next tick's match.
// R11: Counter low byte is count bits 7:0.
// R12: Counter high goes through the shared latch.
// R13: One high-byte latch shared by counter and compare registers.
// R14: Compare A matches counter low in 8-bit.
// R15: Compare B matches counter low byte, in 8-bit only.
// R16: Compare A low, B high, written via latch.
// R17: Software masks interrupts around shared-latch accesses.
// R18: Low-byte write leaves latch contents unchanged.
// R19: Low access moves both bytes in one cycle.
// R20: Software writes high first, reads low first.
// R21: Match sets flag next tick, only A in 16-bit.
// R22: In 16-bit capture, compare pair is capture register.
`timescale 1ns/100ps
`default_nettype none
module tcr_timer
    import tcr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    output logic [7:0] io_rdata,
    input wire logic timer_tick,
    input wire logic capture_input_pin,
    input wire logic comparator_output,
    input wire logic [TCR_FLAG_COUNT-1:0] flag_clear,
    output logic [TCR_FLAG_COUNT-1:0] flags,
    output logic [TCR_FLAG_COUNT-1:0] irq
);
    logic [7:0] timer0_control_a;
    logic [7:0] timer_interrupt_mask;
    logic [15:0] timer_count;
    logic [7:0] compare_a;
    logic [7:0] compare_b;
    logic [7:0] high_latch;
    logic match_block;
    logic [TCR_FILTER_LEN-2:0] filter_shift;
    logic filter_out;
    logic capture_sample;
    logic capture_prev;

    wire width_select = timer0_control_a[TCR_BIT_WIDTH];
    wire capture_mode_enable = timer0_control_a[TCR_BIT_CAP_EN];
    wire capture_filter_enable = timer0_control_a[TCR_BIT_FILTER];
    wire capture_edge_select = timer0_control_a[TCR_BIT_EDGE];
    wire comparator_capture_source = timer0_control_a[TCR_BIT_CMP_SRC];
    wire tcr_seq_t count_sequence_select = tcr_seq_t'(timer0_control_a[TCR_BIT_SEQ]);

    wire wr_ctrl = io_we && io_addr == TCR_ADDR_CTRL_A;
    wire wr_mask = io_we && io_addr == TCR_ADDR_MASK;
    wire wr_cnt_lo = io_we && io_addr == TCR_ADDR_CNT_LO;
    wire wr_cnt_hi = io_we && io_addr == TCR_ADDR_CNT_HI;
    wire wr_cmp_a = io_we && io_addr == TCR_ADDR_CMP_A;
    wire wr_cmp_b = io_we && io_addr == TCR_ADDR_CMP_B;
    wire rd_cnt_lo = io_re && io_addr == TCR_ADDR_CNT_LO;
    wire rd_cnt_hi = io_re && io_addr == TCR_ADDR_CNT_HI;
    wire rd_cmp_a = io_re && io_addr == TCR_ADDR_CMP_A;
    wire rd_cmp_b = io_re && io_addr == TCR_ADDR_CMP_B;
    // Capture in 16-bit mode reads the compare pair through the latch.
    wire cap16 = width_select && capture_mode_enable; // [R22]

    // The comparator path is gated off entirely unless selected.
    wire capture_raw = comparator_capture_source ? comparator_output
                                                 : capture_input_pin; // [R6]
    // The input register is the fourth sample, so the filter adds exactly four cycles.
    wire filter_agree = ({filter_shift, capture_sample} == {TCR_FILTER_LEN{capture_sample}});
    wire next_filter_out = filter_agree ? capture_sample : filter_out; // [R3]
    wire capture_level = capture_filter_enable ? filter_out : capture_sample;
    wire capture_event = capture_mode_enable
        && capture_level != capture_prev
        && capture_level == capture_edge_select; // [R2] [R4]

    wire [15:0] top_value = width_select ? {compare_b, compare_a}
                                         : {TCR_RESET_BYTE, compare_a}; // [R1]
    wire [15:0] live_count = width_select ? timer_count
                                          : {TCR_RESET_BYTE, timer_count[7:0]};
    wire match_a = live_count == top_value; // [R14] [R16]
    wire match_b = !width_select && timer_count[7:0] == compare_b; // [R15]
    wire at_max = width_select ? timer_count == TCR_WORD_MAX
                               : timer_count[7:0] == TCR_BYTE_MAX;
    wire ctc_wrap = count_sequence_select == TCR_SEQ_CTC
        && !capture_mode_enable && match_a; // [R9]
    wire [15:0] count_inc = timer_count + 16'h0001;
    wire [15:0] next_count = ctc_wrap ? TCR_RESET_WORD
        : width_select ? count_inc
        : {timer_count[15:8], count_inc[7:0]};
    // A match is held off for the tick after any counter write.
    wire match_ok = timer_tick && !match_block && !capture_mode_enable; // [R10]

    wire [TCR_FLAG_COUNT-1:0] flag_set;
    assign flag_set[TCR_FLAG_CAP] = capture_event; // [R5]
    assign flag_set[TCR_FLAG_OVF] = timer_tick && at_max && !ctc_wrap;
    assign flag_set[TCR_FLAG_CMP_B] = match_ok && match_b; // [R21]
    assign flag_set[TCR_FLAG_CMP_A] = match_ok && match_a; // [R21]
    // Set beats clear so an event in the clearing cycle is kept.
    wire [TCR_FLAG_COUNT-1:0] next_flags = flag_set | (flags & ~flag_clear);
    wire [TCR_FLAG_COUNT-1:0] irq_enable = {
        timer_interrupt_mask[TCR_BIT_IE_CMP_A],
        timer_interrupt_mask[TCR_BIT_IE_CMP_B],
        timer_interrupt_mask[TCR_BIT_IE_OVF],
        timer_interrupt_mask[TCR_BIT_IE_CAP]}; // [R7]

    // Read data: the latch answers counter high reads in 16-bit mode, and compare B reads only in 16-bit capture.
    wire [7:0] next_rdata =
        (io_addr == TCR_ADDR_CTRL_A) ? (timer0_control_a & TCR_CTRL_A_WMASK) // [R8]
        : (io_addr == TCR_ADDR_MASK) ? (timer_interrupt_mask & TCR_MASK_WMASK)
        : (io_addr == TCR_ADDR_CNT_LO) ? timer_count[7:0] // [R11]
        : (io_addr == TCR_ADDR_CNT_HI) ? (width_select ? high_latch
                                                       : timer_count[15:8]) // [R12]
        : (io_addr == TCR_ADDR_CMP_A) ? compare_a
        : (io_addr == TCR_ADDR_CMP_B) ? (cap16 ? high_latch : compare_b)
        : TCR_RESET_BYTE;

    // The single latch is loaded by high-byte writes and low-byte reads only.
    wire latch_wr = width_select && (wr_cnt_hi || wr_cmp_b); // [R13]
    wire latch_rd = width_select && rd_cnt_lo; // [R19]
    wire latch_cap_rd = cap16 && rd_cmp_a; // [R22]
    wire [7:0] next_latch = latch_wr ? io_wdata
        : latch_rd ? timer_count[15:8]
        : latch_cap_rd ? compare_b
        : high_latch; // [R18]

    // Counter: a CPU write wins over the tick in the same cycle.
    wire [15:0] cpu_count = width_select ? {high_latch, io_wdata} // [R19]
                                         : {timer_count[15:8], io_wdata};
    wire [15:0] next_timer_count = wr_cnt_lo ? cpu_count
        : (wr_cnt_hi && !width_select) ? {io_wdata, timer_count[7:0]}
        : timer_tick ? next_count
        : timer_count;

    // Compare pair: capture loads A, and B only in 16-bit mode; otherwise CPU writes, B via the latch in 16-bit mode.
    wire [7:0] next_compare_a = capture_event ? timer_count[7:0] // [R5]
        : wr_cmp_a ? io_wdata
        : compare_a;
    wire [7:0] next_compare_b = (capture_event && width_select) ? timer_count[15:8]
        : (wr_cmp_a && width_select) ? high_latch // [R16]
        : (wr_cmp_b && !width_select) ? io_wdata
        : compare_b;
    wire next_match_block = (wr_cnt_lo || wr_cnt_hi) ? 1'b1
        : timer_tick ? 1'b0
        : match_block; // [R10]

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timer0_control_a <= TCR_RESET_BYTE;
            timer_interrupt_mask <= TCR_RESET_BYTE;
        end else begin
            if (wr_ctrl) begin
                timer0_control_a <= io_wdata & TCR_CTRL_A_WMASK; // [R8]
            end
            if (wr_mask) begin
                timer_interrupt_mask <= io_wdata & TCR_MASK_WMASK;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timer_count <= TCR_RESET_WORD;
            compare_a <= TCR_RESET_BYTE;
            compare_b <= TCR_RESET_BYTE;
            high_latch <= TCR_RESET_BYTE;
            match_block <= 1'b0;
            io_rdata <= TCR_RESET_BYTE;
        end else begin
            timer_count <= next_timer_count;
            compare_a <= next_compare_a;
            compare_b <= next_compare_b;
            high_latch <= next_latch;
            match_block <= next_match_block;
            io_rdata <= io_re ? next_rdata : TCR_RESET_BYTE;
        end
    end

    // The previous level starts at one so a released reset is no falling edge.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            capture_sample <= 1'b1;
            filter_shift <= {(TCR_FILTER_LEN-1){1'b1}};
            filter_out <= 1'b1;
            capture_prev <= 1'b1;
            flags <= {TCR_FLAG_COUNT{1'b0}};
            irq <= {TCR_FLAG_COUNT{1'b0}};
        end else begin
            capture_sample <= capture_raw;
            filter_shift <= {filter_shift[TCR_FILTER_LEN-3:0], capture_sample}; // [R3]
            filter_out <= next_filter_out;
            capture_prev <= capture_level;
            flags <= next_flags;
            irq <= next_flags & irq_enable;
        end
    end

    default clocking tcr_cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence filter_settled_s;
        capture_filter_enable && filter_agree && capture_sample != filter_out;
    endsequence
    sequence filter_moved_s;
        filter_out == $past(capture_sample);
    endsequence
    sequence lo_write_s;
        io_we && io_addr == TCR_ADDR_CNT_LO && !timer_tick;
    endsequence
    sequence blocked_tick_s;
        match_block && timer_tick && !io_we
            && !flags[TCR_FLAG_CMP_A] && !flags[TCR_FLAG_CMP_B];
    endsequence

    reserved_zero_a: assert property ( // [R8]
        io_re && io_addr == TCR_ADDR_CTRL_A |=> io_rdata[2:1] == 2'b00)
        else $error("reserved control bits read nonzero");
    filter_delay_a: assert property ( // [R3]
        filter_settled_s |=> filter_moved_s)
        else $error("filter output did not follow four equal samples");
    edge_select_a: assert property ( // [R4]
        capture_event |-> capture_level == capture_edge_select
            && $past(capture_level) != capture_level)
        else $error("capture on the wrong edge");
    capture_copy_a: assert property ( // [R5]
        capture_event |=> compare_a == $past(timer_count[7:0])
            && flags[TCR_FLAG_CAP])
        else $error("capture did not copy count and set flag");
    capture_mode_a: assert property ( // [R2]
        !capture_mode_enable |-> !capture_event)
        else $error("capture outside capture mode");
    match_block_a: assert property ( // [R10]
        blocked_tick_s |=> !flags[TCR_FLAG_CMP_A]
            && !flags[TCR_FLAG_CMP_B])
        else $error("compare match not blocked after counter write");
    low_read_latch_a: assert property ( // [R19]
        io_re && io_addr == TCR_ADDR_CNT_LO && width_select && !io_we
        |=> high_latch == $past(timer_count[15:8]))
        else $error("low byte read did not load the latch");
    merged_write_a: assert property ( // [R16]
        wr_cmp_a && width_select && !capture_event
        |=> compare_b == $past(high_latch) && compare_a == $past(io_wdata))
        else $error("16-bit compare write not taken through latch");
    latch_keep_a: assert property ( // [R18]
        wr_cnt_lo && !io_re |=> $stable(high_latch))
        else $error("latch changed on low byte write");
    only_flag_a_a: assert property ( // [R21]
        width_select && !flags[TCR_FLAG_CMP_B] && !match_block
        |=> !flags[TCR_FLAG_CMP_B])
        else $error("compare B flag set in 16-bit mode");
    block_set_a: assert property ( // [R10]
        lo_write_s |=> match_block)
        else $error("counter write did not arm the match block");
    ctc_clear_a: assert property ( // [R9]
        ctc_wrap && timer_tick && !io_we |=> timer_count == TCR_RESET_WORD)
        else $error("clear-on-match did not restart the count");
    width_merge_a: assert property ( // [R1]
        width_select && match_ok && timer_count == {compare_b, compare_a}
        |=> flags[TCR_FLAG_CMP_A])
        else $error("16-bit compare match missed");
    low_byte_read_a: assert property ( // [R11]
        io_re && io_addr == TCR_ADDR_CNT_LO |=> io_rdata == $past(timer_count[7:0]))
        else $error("counter low byte read wrong");
    high_byte_read_a: assert property ( // [R12]
        rd_cnt_hi && width_select |=> io_rdata == $past(high_latch))
        else $error("counter high byte not read from the latch");
    latch_load_a: assert property ( // [R13]
        latch_wr |=> high_latch == $past(io_wdata))
        else $error("high byte write missed the latch");
    low_match_a: assert property ( // [R14]
        !width_select && match_ok && timer_count[7:0] == compare_a
        |=> flags[TCR_FLAG_CMP_A])
        else $error("8-bit compare A match missed");
    b_match_a: assert property ( // [R15]
        !width_select && match_ok && timer_count[7:0] == compare_b
        |=> flags[TCR_FLAG_CMP_B])
        else $error("8-bit compare B match missed");
    cmp_route_a: assert property ( // [R6]
        comparator_capture_source |=> capture_sample == $past(comparator_output))
        else $error("comparator not routed to capture");
    pin_route_a: assert property ( // [R6]
        !comparator_capture_source |=> capture_sample == $past(capture_input_pin))
        else $error("capture pin not routed to capture");
    cap_read_a: assert property ( // [R22]
        cap16 && rd_cmp_a && !io_we |=> high_latch == $past(compare_b))
        else $error("capture low read did not load the latch");
    low_write_a: assert property ( // [R19]
        wr_cnt_lo && width_select |=> timer_count == $past({high_latch, io_wdata}))
        else $error("16-bit counter write not taken in one cycle");
endmodule
`default_nettype wire

// ---- testbench/tcr_capture_source.sv ----
// Behavioural model of the capture pin and analog comparator driving the timer.
`timescale 1ns/100ps
`default_nettype none
module tcr_capture_source (
    input wire logic clock,
    input wire logic go,
    input wire logic use_cmp,
    input wire logic level,
    input wire logic [3:0] delay,
    output logic pin,
    output logic cmp
);
    // Both lines idle high, matching the edge detector's state after reset.
    initial begin
        pin = 1'b1;
        cmp = 1'b1;
    end
    // A slow answer waits delay cycles; the step lands on a falling edge, away from sampling.
    always @(posedge clock) begin
        if (go) begin
            repeat (delay) @(posedge clock);
            @(negedge clock);
            if (use_cmp) cmp <= level;
            else pin <= level;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tcr_timer_tb_top.sv ----
// Self-checking bench for the timer register, compare and capture block.
`timescale 1ns/100ps
`default_nettype none
module tcr_timer_tb_top
    import tcr_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00;
    logic io_we = 1'b0;
    logic io_re = 1'b0;
    logic timer_tick = 1'b0;
    logic [3:0] flag_clear = 4'h0;
    logic go = 1'b0;
    logic use_cmp = 1'b0;
    logic level = 1'b1;
    logic [3:0] delay = 4'h0;
    logic [7:0] io_rdata;
    logic [3:0] flags;
    logic [3:0] irq;
    logic pin;
    logic cmp;
    logic [15:0] cnt;
    int n_mismatch = 0;
    int n_compared = 0;
    always #2 clock = ~clock;
    tcr_timer dut (.clock(clock), .reset(reset), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .timer_tick(timer_tick),
        .capture_input_pin(pin), .comparator_output(cmp), .flag_clear(flag_clear),
        .flags(flags), .irq(irq));
    tcr_capture_source src (.clock(clock), .go(go), .use_cmp(use_cmp), .level(level),
        .delay(delay), .pin(pin), .cmp(cmp));
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end
        else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Every access leaves one idle cycle so no strobe is lowered and raised in one step.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(negedge clock);
        io_we = 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        io_addr = a;
        io_re = 1'b1;
        @(negedge clock);
        io_re = 1'b0;
        chk_byte("read data", exp, io_rdata);
        @(negedge clock);
    endtask
    task automatic set16(input logic [5:0] hi, input logic [5:0] lo, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic tick;
        timer_tick = 1'b1;
        @(negedge clock);
        timer_tick = 1'b0;
        @(negedge clock);
    endtask
    task automatic clr;
        flag_clear = 4'hF;
        @(negedge clock);
        flag_clear = 4'h0;
        @(negedge clock);
    endtask
    // Returns at the falling edge on which the selected line changes.
    task automatic step_line(input logic l, input logic [3:0] d);
        level = l;
        delay = d;
        go = 1'b1;
        @(negedge clock);
        go = 1'b0;
        repeat (d) @(negedge clock);
    endtask
    initial begin
        #50000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (3) @(negedge clock);
        reset = 1'b0;
        rd(TCR_ADDR_CTRL_A, 8'h00);
        wr(TCR_ADDR_CTRL_A, 8'hFF);
        rd(TCR_ADDR_CTRL_A, 8'hF9);
        wr(TCR_ADDR_MASK, 8'hFF);
        rd(TCR_ADDR_MASK, 8'h1B);
        rd(6'h3F, 8'h00);
        wr(TCR_ADDR_CTRL_A, 8'h80);
        set16(TCR_ADDR_CNT_HI, TCR_ADDR_CNT_LO, 16'h01FF);
        rd(TCR_ADDR_CNT_LO, 8'hFF);
        rd(TCR_ADDR_CNT_HI, 8'h01);
        set16(TCR_ADDR_CMP_B, TCR_ADDR_CMP_A, 16'h1234);
        wr(TCR_ADDR_CNT_LO, 8'h34);
        rd(TCR_ADDR_CNT_LO, 8'h34);
        rd(TCR_ADDR_CNT_HI, 8'h12);
        rd(TCR_ADDR_CMP_A, 8'h34);
        rd(TCR_ADDR_CMP_B, 8'h12);
        clr;
        tick;
        chk_bit("compare A flag", 1'b0, flags[TCR_FLAG_CMP_A]);
        wr(TCR_ADDR_CNT_LO, 8'h33);
        tick;
        tick;
        chk_bit("compare A flag", 1'b1, flags[TCR_FLAG_CMP_A]);
        chk_bit("compare B flag", 1'b0, flags[TCR_FLAG_CMP_B]);
        chk_bit("compare A irq", 1'b1, irq[TCR_FLAG_CMP_A]);
        for (int s = 0; s < 2; s++) begin
            wr(TCR_ADDR_CTRL_A, {7'h00, s[0]});
            wr(TCR_ADDR_CMP_A, 8'h10);
            wr(TCR_ADDR_CMP_B, 8'h10);
            wr(TCR_ADDR_CNT_LO, 8'h0F);
            clr;
            tick;
            tick;
            chk_bit("compare A flag", 1'b1, flags[TCR_FLAG_CMP_A]);
            chk_bit("compare B flag", 1'b1, flags[TCR_FLAG_CMP_B]);
            chk_bit("compare B irq", 1'b1, irq[TCR_FLAG_CMP_B]);
            rd(TCR_ADDR_CNT_LO, s[0] ? 8'h00 : 8'h11);
        end
        wr(TCR_ADDR_CTRL_A, 8'h00);
        wr(TCR_ADDR_CNT_LO, 8'hFF);
        clr;
        tick;
        chk_bit("overflow flag", 1'b1, flags[TCR_FLAG_OVF]);
        chk_bit("overflow irq", 1'b1, irq[TCR_FLAG_OVF]);
        for (int i = 0; i < 8; i++) begin
            use_cmp = i[2];
            wr(TCR_ADDR_CTRL_A, {2'b11, i[0], i[1], i[2], 3'b000});
            step_line(~i[1], 4'h0);
            repeat (12) @(negedge clock);
            cnt = 16'hA500 | i[15:0];
            set16(TCR_ADDR_CNT_HI, TCR_ADDR_CNT_LO, cnt);
            clr;
            step_line(i[1], {3'b000, i[2]});
            @(negedge clock);
            chk_bit("capture flag early", 1'b0, flags[TCR_FLAG_CAP]);
            repeat (4) @(negedge clock);
            chk_bit("capture flag filtered", ~i[0], flags[TCR_FLAG_CAP]);
            @(negedge clock);
            chk_bit("capture flag", 1'b1, flags[TCR_FLAG_CAP]);
            chk_bit("capture irq", 1'b1, irq[TCR_FLAG_CAP]);
            rd(TCR_ADDR_CMP_A, cnt[7:0]);
            rd(TCR_ADDR_CMP_B, cnt[15:8]);
        end
        clr;
        use_cmp = 1'b0;
        step_line(1'b0, 4'h0);
        repeat (12) @(negedge clock);
        step_line(1'b1, 4'h0);
        repeat (12) @(negedge clock);
        chk_bit("pin ignored", 1'b0, flags[TCR_FLAG_CAP]);
        test_done();
    end
endmodule
`default_nettype wire
